/* shared/hsr_pkg.sv */
// Constants and types for the host strobe and indirect read block
package hsr_pkg;
	// ==========================================================
	// Sizes and reset release
	localparam int HSR_CHANNELS = 4;
	localparam int HSR_ORDER_ENTRIES = 32;
	localparam int RST_RELEASE_EDGES = 4;
	// ==========================================================
	// Direct host port addresses
	localparam logic [2:0] DIR_DATA_LO = 3'h0;
	localparam logic [2:0] DIR_DATA_HI = 3'h1;
	localparam logic [2:0] DIR_ORDER = 3'h2;
	localparam logic [2:0] DIR_IRA = 3'h3;
	localparam logic [2:0] DIR_IWA = 3'h4;
	// ==========================================================
	// Global addresses
	localparam logic [15:0] GWA_TEST_STROBE = 16'hF808;
	localparam logic [15:0] GWA_SYNC_STROBE = 16'hF809;
	localparam logic [15:0] GWA_ORDER_FIRST = 16'hF820;
	localparam logic [15:0] GWA_ORDER_LAST = 16'hF83F;
	localparam logic [15:0] IRA_LEVEL_DET = 16'hF806;
	// ==========================================================
	// Per-channel offsets and channel nibble
	localparam logic [3:0] CHAN_LAST = 4'h3;
	localparam logic [3:0] CHAN_ALL = 4'hF;
	localparam logic [11:0] OFF_CARRIER = 12'h006;
	localparam logic [11:0] OFF_TIMING = 12'h009;
	localparam logic [11:0] OFF_WAIT = 12'h00C;
	localparam logic [11:0] OFF_GAIN = 12'h00F;
	localparam logic [11:0] INSTR_FIRST = 12'h100;
	localparam logic [11:0] INSTR_LAST = 12'h17F;
	localparam logic [11:0] PTR_FIRST = 12'h180;
	localparam logic [11:0] PTR_LAST = 12'h1FC;
	localparam logic [11:0] HBF_FIRST = 12'h400;
	localparam logic [11:0] HBF_LAST = 12'h43F;
	localparam logic [11:0] CRAM1_FIRST = 12'h440;
	localparam logic [11:0] CRAM1_LAST = 12'h47F;
	localparam logic [11:0] CRAM2_FIRST = 12'h480;
	localparam logic [11:0] CRAM2_LAST = 12'h4FF;
	localparam logic [11:0] RSMP_FIRST = 12'h500;
	localparam logic [11:0] RSMP_LAST = 12'h5FF;
	// ==========================================================
	// Word type codes of a read-order entry
	localparam logic [2:0] WT_I_HI = 3'h0;
	localparam logic [2:0] WT_I_LO = 3'h1;
	localparam logic [2:0] WT_Q_HI = 3'h2;
	localparam logic [2:0] WT_Q_LO = 3'h3;
	localparam logic [2:0] WT_MAG_HI = 3'h4;
	localparam logic [2:0] WT_MAG_LO = 3'h5;
	localparam logic [2:0] WT_PHASE = 3'h6;
	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		REG_NONE = 3'b000, REG_INSTR = 3'b001, REG_PTR = 3'b011, REG_HBF = 3'b010,
		REG_CRAM1 = 3'b110, REG_CRAM2 = 3'b111, REG_RSMP = 3'b101
	} hsr_region_t;
	typedef struct packed {
		logic ceN;
		logic wrN;
		logic rdN;
		logic [2:0] addr;
		logic [15:0] data;
	} hsr_bus_t;
	localparam hsr_bus_t BUS_IDLE = '{ceN: 1'b1, wrN: 1'b1, rdN: 1'b1, addr: 3'h0, data: 16'h0000};
	typedef struct packed {
		logic [23:0] i;
		logic [23:0] q;
		logic [23:0] mag;
		logic [15:0] phase;
		logic [15:0] gain;
		logic [31:0] carrierFreq;
		logic [31:0] timingFreq;
		logic [31:0] waitDecr;
	} hsr_chan_src_t;
	typedef struct packed {
		hsr_region_t region;
		logic [1:0] chan;
		logic [11:0] offset;
	} hsr_fetch_t;
endpackage

/* design/hsr_host_strobe_read.sv */
// Host strobe generation, read-order bank and indirect read path
`timescale 1ns/100ps
// Overview of operation
// - Write to F808 strobes sample-valid on channels whose select bit picks it.
// - Write to F809 gives a pulse one clock wide on the align output.
// - Align path may hold zero to two pipeline stages; sync still works.
// - Read-order entries F820..F83F hold five bits: channel above, word type below.
// - Types 000..011 return I or Q upper word, or low byte then zeros.
// - Type 100 returns magnitude upper word, 101 its low byte then zeros.
// - Type 110 returns upper phase word, 111 upper gain word.
// - Each address write strobes a fetch where needed; host rewrites for fresh data.
// - Live sources read repeatedly at direct 0 and 1 without rewriting.
// - Gain is sampled by its own indirect write, for the selected channel, or all channels at once with nibble F.
// - Top nibble selects channel; only 0..3 and F are valid.
// - Offsets 006, 009, 00C return carrier, timing and wait values.
// - 100..17F return instruction memory, 180..1FC the pointer memory.
// - 400..5FF return halfband ROM, two coefficient RAMs and resampler ROM.
// - Global F806 returns the input level detector accumulator.
// - Reset enters at once, leaves on fourth rising edge after release.
module hsr_host_strobe_read #(
	parameter int CHANNELS = hsr_pkg::HSR_CHANNELS
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Host parallel bus
	input wire hsr_pkg::hsr_bus_t hostBus,
	output logic [15:0] hostDataOut,
	output logic hostDataOe,
	// Channel sources
	input wire hsr_pkg::hsr_chan_src_t chanSrc [CHANNELS],
	input wire logic [CHANNELS-1:0] chanStrobeSel,
	input wire logic [31:0] memRdData,
	input wire logic [31:0] levelAcc,
	// Strobes to the channels
	output logic [CHANNELS-1:0] sampleValidStrobe,
	output logic chainAlignPulseOut,
	output logic fetchStrobe,
	output hsr_pkg::hsr_fetch_t fetchSel
);
	import hsr_pkg::*;

	// ==========================================================
	// Elaboration check
	if (CHANNELS != HSR_CHANNELS) begin : g_bad_channels
		$error("Channel field is two bits wide; CHANNELS must be four");
	end

	// ==========================================================
	// Functions
	function automatic logic chan_ok(input logic [3:0] n);
		return (n <= CHAN_LAST) || (n == CHAN_ALL);
	endfunction

	function automatic logic [1:0] chan_idx(input logic [3:0] n);
		return (n == CHAN_ALL) ? 2'h0 : n[1:0];
	endfunction

	function automatic hsr_region_t region_of(input logic [11:0] off);
		if (off >= INSTR_FIRST && off <= INSTR_LAST) return REG_INSTR;
		if (off >= PTR_FIRST && off <= PTR_LAST) return REG_PTR;
		if (off >= HBF_FIRST && off <= HBF_LAST) return REG_HBF;
		if (off >= CRAM1_FIRST && off <= CRAM1_LAST) return REG_CRAM1;
		if (off >= CRAM2_FIRST && off <= CRAM2_LAST) return REG_CRAM2;
		if (off >= RSMP_FIRST && off <= RSMP_LAST) return REG_RSMP;
		return REG_NONE;
	endfunction

	function automatic logic [15:0] order_word(input logic [2:0] wt, input hsr_chan_src_t c);
		case (wt)
			WT_I_HI: return c.i[23:8];
			WT_I_LO: return {c.i[7:0], 8'h00};
			WT_Q_HI: return c.q[23:8];
			WT_Q_LO: return {c.q[7:0], 8'h00};
			WT_MAG_HI: return c.mag[23:8];
			WT_MAG_LO: return {c.mag[7:0], 8'h00};
			WT_PHASE: return c.phase;
			default: return c.gain;
		endcase
	endfunction

	// ==========================================================
	// Reset release
	logic [2:0] rstPipe;
	logic runReg;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rstPipe <= 3'h0;
			runReg <= 1'b0;
		end else begin
			rstPipe <= {rstPipe[1:0], 1'b1};
			runReg <= rstPipe[2];
		end
	end

	// ==========================================================
	// Host pin synchroniser
	// Third stage only feeds edge detection and holds a stable address and data.
	hsr_bus_t busS1;
	hsr_bus_t busS2;
	hsr_bus_t busS3;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			busS1 <= BUS_IDLE;
			busS2 <= BUS_IDLE;
			busS3 <= BUS_IDLE;
		end else begin
			busS1 <= hostBus;
			busS2 <= busS1;
			busS3 <= busS2;
		end
	end

	logic wrTake;
	logic rdDone;
	logic iwaWrite;
	logic iraWrite;
	logic [15:0] iwaAddr;

	// Writes take effect on the rising edge of the write strobe.
	assign wrTake = runReg && !busS3.wrN && busS2.wrN && !busS3.ceN;
	assign rdDone = runReg && !busS3.rdN && busS2.rdN && !busS3.ceN;
	assign iwaWrite = wrTake && (busS3.addr == DIR_IWA);
	assign iraWrite = wrTake && (busS3.addr == DIR_IRA);
	assign iwaAddr = busS3.data;

	// ==========================================================
	// Write holding data
	logic [15:0] holdLo;
	logic [15:0] holdHi;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			holdLo <= 16'h0000;
			holdHi <= 16'h0000;
		end else if (wrTake && busS3.addr == DIR_DATA_LO) begin
			holdLo <= busS3.data;
		end else if (wrTake && busS3.addr == DIR_DATA_HI) begin
			holdHi <= busS3.data;
		end
	end

	// ==========================================================
	// Strobe locations
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sampleValidStrobe <= '0;
			chainAlignPulseOut <= 1'b0;
		end else begin
			// Only channels steered to the write-made strobe see it
			sampleValidStrobe <= (iwaWrite && iwaAddr == GWA_TEST_STROBE) ?
				chanStrobeSel : '0;
			// Registered single pulse; downstream stages only add latency
			chainAlignPulseOut <= iwaWrite && (iwaAddr == GWA_SYNC_STROBE);
		end
	end

	// ==========================================================
	// Read-order bank
	logic [4:0] orderReg [HSR_ORDER_ENTRIES];
	logic [4:0] orderPtr;
	logic orderHit;

	assign orderHit = iwaAddr >= GWA_ORDER_FIRST && iwaAddr <= GWA_ORDER_LAST;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (int k = 0; k < HSR_ORDER_ENTRIES; k++) begin
				orderReg[k] <= 5'h00;
			end
		end else if (iwaWrite && orderHit) begin
			orderReg[iwaAddr[4:0]] <= holdLo[4:0];
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			orderPtr <= 5'h00;
		end else if (rdDone && busS3.addr == DIR_ORDER) begin
			orderPtr <= orderPtr + 5'h01;
		end
	end

	// ==========================================================
	// Gain sampling
	logic [15:0] gainHold [CHANNELS];

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (int c = 0; c < CHANNELS; c++) begin
				gainHold[c] <= 16'h0000;
			end
		end else if (iwaWrite && iwaAddr[11:0] == OFF_GAIN) begin
			for (int c = 0; c < CHANNELS; c++) begin
				// Broadcast nibble catches every channel in one cycle
				if (iwaAddr[15:12] == CHAN_ALL || iwaAddr[15:12] == 4'(c)) begin
					gainHold[c] <= chanSrc[c].gain;
				end
			end
		end
	end

	// ==========================================================
	// Indirect read address and fetch strobe
	logic [15:0] iraReg;
	logic iraNeedsFetch;

	assign iraNeedsFetch = busS3.data != IRA_LEVEL_DET && chan_ok(busS3.data[15:12]) &&
		region_of(busS3.data[11:0]) != REG_NONE;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			iraReg <= 16'h0000;
			fetchStrobe <= 1'b0;
			fetchSel <= '{region: REG_NONE, chan: 2'h0, offset: 12'h000};
		end else begin
			fetchStrobe <= iraWrite && iraNeedsFetch;
			if (iraWrite) begin
				iraReg <= busS3.data;
				fetchSel <= '{region: region_of(busS3.data[11:0]),
					chan: chan_idx(busS3.data[15:12]), offset: busS3.data[11:0]};
			end
		end
	end

	// ==========================================================
	// Read source selection
	logic [31:0] srcWord;
	logic [31:0] readWord;
	logic [1:0] iraChan;

	assign iraChan = chan_idx(iraReg[15:12]);

	always_comb begin
		srcWord = 32'h0000_0000;
		if (iraReg == IRA_LEVEL_DET) begin
			srcWord = levelAcc;
		end else if (iraReg >= GWA_ORDER_FIRST && iraReg <= GWA_ORDER_LAST) begin
			srcWord = {27'h0000000, orderReg[iraReg[4:0]]};
		end else if (chan_ok(iraReg[15:12])) begin
			case (iraReg[11:0])
				OFF_CARRIER: srcWord = chanSrc[iraChan].carrierFreq;
				OFF_TIMING: srcWord = chanSrc[iraChan].timingFreq;
				OFF_WAIT: srcWord = chanSrc[iraChan].waitDecr;
				OFF_GAIN: srcWord = {16'h0000, gainHold[iraChan]};
				default: begin
					if (region_of(iraReg[11:0]) != REG_NONE) begin
						srcWord = memRdData;
					end
				end
			endcase
		end
	end

	// Refreshed every cycle so live sources need no address rewrite
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			readWord <= 32'h0000_0000;
		end else begin
			readWord <= srcWord;
		end
	end

	// ==========================================================
	// Host read data
	logic [4:0] orderSel;

	assign orderSel = orderReg[orderPtr];

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			hostDataOut <= 16'h0000;
			hostDataOe <= 1'b0;
		end else begin
			hostDataOe <= runReg && !busS2.rdN && !busS2.ceN;
			case (busS2.addr)
				DIR_DATA_LO: hostDataOut <= readWord[15:0];
				DIR_DATA_HI: hostDataOut <= readWord[31:16];
				DIR_ORDER: hostDataOut <= order_word(orderSel[2:0], chanSrc[orderSel[4:3]]);
				default: hostDataOut <= 16'h0000;
			endcase
		end
	end

	// ==========================================================
	// Assertions
	property p_sync_single;
		@(posedge clock) disable iff (!rst_b)
		chainAlignPulseOut |=> !chainAlignPulseOut;
	endproperty
	a_sync_single: assert property (p_sync_single) else $error("Align pulse too wide");

	property p_sync_cause;
		@(posedge clock) disable iff (!rst_b)
		iwaWrite && iwaAddr == GWA_SYNC_STROBE |=> chainAlignPulseOut;
	endproperty
	a_sync_cause: assert property (p_sync_cause) else $error("Align pulse missing");

	property p_strobe_sel;
		@(posedge clock) disable iff (!rst_b)
		iwaWrite && iwaAddr == GWA_TEST_STROBE |=> sampleValidStrobe == $past(chanStrobeSel);
	endproperty
	a_strobe_sel: assert property (p_strobe_sel) else $error("Sample strobe mismatch");

	property p_strobe_cause;
		@(posedge clock) disable iff (!rst_b)
		sampleValidStrobe != '0 |-> $past(iwaWrite) && $past(iwaAddr) == GWA_TEST_STROBE;
	endproperty
	a_strobe_cause: assert property (p_strobe_cause) else $error("Stray sample strobe");

	property p_order_store;
		@(posedge clock) disable iff (!rst_b)
		iwaWrite && orderHit |=> orderReg[$past(iwaAddr[4:0])] == $past(holdLo[4:0]);
	endproperty
	a_order_store: assert property (p_order_store) else $error("Order entry not stored");

	property p_fetch;
		@(posedge clock) disable iff (!rst_b)
		iraWrite && iraNeedsFetch |=> fetchStrobe ##1 !fetchStrobe[*1];
	endproperty
	a_fetch: assert property (p_fetch) else $error("Fetch strobe wrong");

	property p_level_live;
		@(posedge clock) disable iff (!rst_b)
		iraReg == IRA_LEVEL_DET ##1 iraReg == IRA_LEVEL_DET |-> readWord == $past(levelAcc);
	endproperty
	a_level_live: assert property (p_level_live) else $error("Level readback stale");

	property p_bad_chan;
		@(posedge clock) disable iff (!rst_b)
		!chan_ok(iraReg[15:12]) && iraReg[15:12] != 4'hF |=> readWord == 32'h0000_0000;
	endproperty
	a_bad_chan: assert property (p_bad_chan) else $error("Invalid channel returned data");

	property p_reset_release;
		@(posedge clock) disable iff (!rst_b)
		$rose(runReg) |-> !$past(rstPipe[0], 4) && $past(rstPipe[0], 3);
	endproperty
	a_reset_release: assert property (p_reset_release) else $error("Reset release edge");

	property p_gain_all;
		@(posedge clock) disable iff (!rst_b)
		iwaWrite && iwaAddr == {CHAN_ALL, OFF_GAIN} |=>
			gainHold[0] == $past(chanSrc[0].gain) && gainHold[3] == $past(chanSrc[3].gain);
	endproperty
	a_gain_all: assert property (p_gain_all) else $error("Gain not sampled together");
endmodule

/* verification/hsr_host_model.sv */
// Host processor model for the parallel register bus
`timescale 1ns/100ps
module hsr_host_model (
	// Clock
	input wire logic clock,
	// Device bus
	output hsr_pkg::hsr_bus_t hostBus,
	input wire logic [15:0] hostDataOut,
	input wire logic hostDataOe
);
	import hsr_pkg::*;
	// ==========================================================
	// Bus cycles, every change on the falling edge
	initial begin
		hostBus = BUS_IDLE;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge clock);
	endtask
	// Write strobe held three clocks, select two more; the sync needs no select after the strobe
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		hostBus = '{ceN: 1'b0, wrN: 1'b0, rdN: 1'b1, addr: a, data: d};
		hold(3);
		hostBus.wrN = 1'b1;
		hold(2);
		hostBus.ceN = 1'b1;
		// Released lines float, so never show the old value
		hostBus.data = ~d;
		hold(3);
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] d, output logic oe);
		hostBus.addr = a;
		hostBus.ceN = 1'b0;
		hostBus.rdN = 1'b0;
		hold(4);
		d = hostDataOut;
		oe = hostDataOe;
		hostBus.rdN = 1'b1;
		hostBus.ceN = 1'b1;
		hold(4);
	endtask
	// Select a source; rewritten before each fresh fetch
	task automatic indirect_read_space(input logic [15:0] a);
		wr(DIR_IRA, a);
		hold(3);
	endtask
endmodule

/* verification/hsr_host_strobe_read_tb.sv */
// Self-checking bench for the host strobe and indirect read block
`timescale 1ns/100ps
module hsr_host_strobe_read_tb;
	import hsr_pkg::*;
	// ==========================================================
	// Signals, tables and monitors
	localparam hsr_chan_src_t BASE = 200'h12_3456_789A_BCDE_F0FE_DCBA_9876_5432_1013_5792_4680_ACE1_BDF0;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	hsr_bus_t hostBus;
	hsr_chan_src_t chanSrc [HSR_CHANNELS];
	hsr_fetch_t fetchSel;
	logic [15:0] hostDataOut;
	logic [15:0] rdData;
	logic [15:0] g;
	logic [31:0] w;
	logic [31:0] memRdData = 32'hA5C3_9E17;
	logic [31:0] levelAcc = 32'h1357_2468;
	logic [3:0] chanStrobeSel = 4'h0;
	logic [3:0] sampleValidStrobe;
	logic [4:0] code;
	logic hostDataOe, chainAlignPulseOut, fetchStrobe, rdOe;
	logic [3:0] sels [2] = '{4'h5, 4'hA};
	logic [3:0] nibs [4] = '{4'h5, 4'hF, 4'h1, 4'h3};
	logic [11:0] offs [3] = '{OFF_CARRIER, OFF_TIMING, OFF_WAIT};
	logic [11:0] mems [14] = '{12'h100, 12'h17F, 12'h180, 12'h1FC, 12'h400, 12'h43F,
		12'h440, 12'h47F, 12'h480, 12'h4FF, 12'h500, 12'h5FF, 12'h1FD, 12'h600};
	hsr_region_t regs [14] = '{REG_INSTR, REG_INSTR, REG_PTR, REG_PTR, REG_HBF, REG_HBF,
		REG_CRAM1, REG_CRAM1, REG_CRAM2, REG_CRAM2, REG_RSMP, REG_RSMP, REG_NONE, REG_NONE};
	int miscompares = 0;
	int total_checks = 0;
	int alignCnt = 0;
	int alignFarCnt = 0;
	logic [1:0] alignDly = 2'b00;
	int fetchCnt = 0;
	int svCnt [4] = '{0, 0, 0, 0};
	int s0 [4];
	int c0, a0;
	always #5 clock = ~clock;
	always @(posedge clock) begin
		alignCnt <= alignCnt + int'(chainAlignPulseOut);
		fetchCnt <= fetchCnt + int'(fetchStrobe);
		// Far side with two pipeline stages on the align path
		alignDly <= {alignDly[0], chainAlignPulseOut};
		alignFarCnt <= alignFarCnt + int'(alignDly[1]);
		for (int k = 0; k < 4; k++) begin
			svCnt[k] <= svCnt[k] + int'(sampleValidStrobe[k]);
		end
	end
	hsr_host_model host (.clock(clock), .hostBus(hostBus), .hostDataOut(hostDataOut),
		.hostDataOe(hostDataOe));
	hsr_host_strobe_read #(.CHANNELS(HSR_CHANNELS)) uut (.clock(clock), .rst_b(rst_b),
		.hostBus(hostBus), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
		.chanSrc(chanSrc), .chanStrobeSel(chanStrobeSel), .memRdData(memRdData),
		.levelAcc(levelAcc), .sampleValidStrobe(sampleValidStrobe),
		.chainAlignPulseOut(chainAlignPulseOut), .fetchStrobe(fetchStrobe),
		.fetchSel(fetchSel));
	// ==========================================================
	// Expected words and shared tasks
	function automatic logic [15:0] orderWord(input logic [4:0] sel);
		hsr_chan_src_t s;
		s = chanSrc[sel[4:3]];
		case (sel[2:0])
			3'h0: return s.i[23:8];
			3'h1: return {s.i[7:0], 8'h00};
			3'h2: return s.q[23:8];
			3'h3: return {s.q[7:0], 8'h00};
			3'h4: return s.mag[23:8];
			3'h5: return {s.mag[7:0], 8'h00};
			3'h6: return s.phase;
			default: return s.gain;
		endcase
	endfunction
	function automatic logic [31:0] liveWord(input logic [3:0] nib, input int k);
		hsr_chan_src_t s;
		s = chanSrc[nib[1:0] & {2{nib != CHAN_ALL}}];
		if (nib > CHAN_LAST && nib != CHAN_ALL) begin
			return 32'h0000_0000;
		end
		return k == 0 ? s.carrierFreq : (k == 1 ? s.timingFreq : s.waitDecr);
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic iwrite(input logic [15:0] a, input logic [15:0] d);
		host.wr(DIR_DATA_LO, d);
		host.wr(DIR_IWA, a);
	endtask
	task automatic rdWord(output logic [31:0] v);
		host.rd(DIR_DATA_LO, v[15:0], rdOe);
		check(32'(rdOe), 32'h1);
		host.rd(DIR_DATA_HI, v[31:16], rdOe);
	endtask
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ==========================================================
	// Tests
	initial begin
		// Whole sequence needs about 1300 clocks
		#200us;
		miscompares++;
		print_verdict();
	end
	initial begin
		for (int c = 0; c < 4; c++) begin
			chanSrc[c] = BASE ^ {25{8'(c * 8'h11)}};
		end
		#12;
		check({27'h0, sampleValidStrobe, chainAlignPulseOut}, 32'h0);
		check({30'h0, fetchStrobe, hostDataOe}, 32'h0);
		@(negedge clock);
		rst_b = 1'b1;
		repeat (5) @(negedge clock);
		fork
			host.rd(DIR_DATA_LO, rdData, rdOe);
			begin
				repeat (4) @(negedge clock);
				check(32'(hostDataOe), 32'h1);
				rst_b = 1'b0;
				#1;
				check(32'(hostDataOe), 32'h0);
			end
		join
		rst_b = 1'b1;
		repeat (5) @(negedge clock);
		$display("test reset done");
		for (int n = 0; n < 9; n++) begin
			code = (n < 8) ? 5'h10 + 5'(n) : 5'h18;
			iwrite(GWA_ORDER_FIRST + 16'(n), 16'hAB00 | 16'(code));
		end
		for (int n = 0; n < 9; n++) begin
			code = (n < 8) ? 5'h10 + 5'(n) : 5'h18;
			host.rd(DIR_ORDER, rdData, rdOe);
			check({16'h0, rdData}, {16'h0, orderWord(code)});
		end
		iwrite(GWA_ORDER_LAST, 16'hFFFD);
		host.indirect_read_space(GWA_ORDER_LAST);
		rdWord(w);
		check({16'h0, w[15:0]}, 32'h0000_001D);
		$display("test read order done");
		foreach (sels[j]) begin
			chanStrobeSel = sels[j];
			c0 = alignCnt;
			a0 = alignFarCnt;
			s0 = svCnt;
			iwrite(GWA_TEST_STROBE, 16'h0000);
			iwrite(GWA_SYNC_STROBE, {12'h000, sels[j]});
			// Let the pulse clear both far-side stages
			repeat (2) @(negedge clock);
			for (int k = 0; k < 4; k++) begin
				check(32'(svCnt[k] - s0[k]), 32'(sels[j][k]));
			end
			check(32'(alignCnt - c0), 32'h1);
			check(32'(alignFarCnt - a0), 32'h1);
		end
		$display("test strobes done");
		foreach (offs[k]) begin
			foreach (nibs[j]) begin
				host.indirect_read_space({nibs[j], offs[k]});
				rdWord(w);
				check(w, liveWord(nibs[j], k));
			end
		end
		chanSrc[3].waitDecr = 32'hC0DE_0BAD;
		repeat (2) @(negedge clock);
		rdWord(w);
		check(w, 32'hC0DE_0BAD);
		host.indirect_read_space(IRA_LEVEL_DET);
		rdWord(w);
		check(w, levelAcc);
		levelAcc = 32'h0F0F_5A5A;
		repeat (2) @(negedge clock);
		rdWord(w);
		check(w, 32'h0F0F_5A5A);
		$display("test live reads done");
		iwrite({4'h2, OFF_GAIN}, 16'h0000);
		g = chanSrc[2].gain;
		chanSrc[2].gain = ~g;
		host.indirect_read_space({4'h2, OFF_GAIN});
		rdWord(w);
		check({16'h0, w[15:0]}, {16'h0, g});
		iwrite({4'h2, OFF_GAIN}, 16'h0000);
		host.indirect_read_space({4'h2, OFF_GAIN});
		rdWord(w);
		check({16'h0, w[15:0]}, {16'h0, ~g});
		// Broadcast sample; each source moves only after the capture
		iwrite({CHAN_ALL, OFF_GAIN}, 16'h0000);
		for (int c = 0; c < 4; c++) begin
			g = chanSrc[c].gain;
			chanSrc[c].gain = ~g;
			host.indirect_read_space({4'(c), OFF_GAIN});
			rdWord(w);
			check({16'h0, w[15:0]}, {16'h0, g});
		end
		$display("test gain sample done");
		foreach (mems[j]) begin
			c0 = fetchCnt;
			host.indirect_read_space({4'h2, mems[j]});
			rdWord(w);
			check(32'(fetchCnt - c0), 32'(regs[j] != REG_NONE));
			check(32'(fetchSel.region), 32'(regs[j]));
			check(32'({fetchSel.chan, fetchSel.offset}), {18'h0, 2'h2, mems[j]});
			check(w, regs[j] != REG_NONE ? memRdData : 32'h0);
		end
		$display("test memory fetch done");
		print_verdict();
	end
endmodule
